//--- core/ubt_pkg.sv
// Constants, types and shared helpers for the baud tick and receive sampler
package ubt_pkg;
  // Register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_DIV = 8'h04;
  localparam logic [7:0] ADR_BITLEN = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0C;
  localparam logic [7:0] ADR_DATA = 8'h10;
  // Control field positions
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_TX_EN = 1;
  localparam int CTRL_PAR = 2;
  localparam int CTRL_STOP = 3;
  localparam int CTRL_BASE_LO = 4;
  // Status field positions
  localparam int STAT_RX_BUSY = 0;
  localparam int STAT_TX_BUSY = 1;
  localparam int STAT_RX_VALID = 2;
  localparam int STAT_OVERRUN = 3;
  localparam int STAT_FALSE_LO = 8;
  // Receive data word field positions
  localparam int DATA_PERR = 8;
  localparam int DATA_FERR = 9;
  localparam int DATA_VALID = 10;
  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [2:0] BITLEN_RST = 3'h0;
  // Bit-length selector codes
  localparam logic [2:0] BL_16 = 3'h0;
  localparam logic [2:0] BL_16_17 = 3'h1;
  localparam logic [2:0] BL_15 = 3'h2;
  localparam logic [2:0] BL_15_16 = 3'h3;
  localparam logic [2:0] BL_17 = 3'h4;
  // Down-count values at which the input is sampled
  localparam logic [4:0] SAMPLE_FIRST = 5'h08;
  localparam logic [4:0] SAMPLE_MID = 5'h07;
  localparam logic [4:0] SAMPLE_LAST = 5'h06;
  // Index of the first stop bit without parity
  localparam logic [3:0] FRAME_LAST_BASE = 4'h9;
  localparam int FIFO_WIDTH = 10;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} ubt_state_t;

  // Sub-bit ticks in one bit; phase 0 is the shorter of an alternating pair
  function automatic logic [4:0] bit_ticks(input logic [2:0] sel, input logic phase);
    logic [4:0] n;
    n = 5'h10;
    unique case (sel)
      BL_16: n = 5'h10;
      BL_16_17: n = phase ? 5'h11 : 5'h10;
      BL_15: n = 5'h0F;
      BL_15_16: n = phase ? 5'h10 : 5'h0F;
      BL_17: n = 5'h11;
      default: n = 5'h10;
    endcase
    return n;
  endfunction

  function automatic logic majority(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction
endpackage

//--- core/ubt_mem.sv
// Simple dual-port word memory with registered read data
module ubt_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] wa,
  input wire logic [WIDTH-1:0] wd,
  // Read port
  input wire logic re,
  input wire logic [$clog2(DEPTH)-1:0] ra,
  output logic [WIDTH-1:0] rq
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
    if (re) begin
      rq <= mem[ra];
    end
  end
endmodule

//--- core/ubt_fifo.sv
// Valid/ready FIFO built on the word memory
module ubt_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic pend;
  logic wr;
  logic rd;
  logic [WIDTH-1:0] rq;

  assign in_ready = cnt != FULL;
  assign wr = in_valid & in_ready;
  // One read in flight at a time, issued only when the output stage can take it
  assign rd = (cnt != '0) & ~pend & (~out_valid | out_ready);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      pend <= 1'b0;
    end else begin
      if (wr) begin
        wp <= wp + 1'b1;
      end
      if (rd) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
      pend <= rd;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pend) begin
      out_valid <= 1'b1;
      out_data <= rq;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  ubt_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .clk(clk),
    .we(wr),
    .wa(wp),
    .wd(in_data),
    .re(rd),
    .ra(rp),
    .rq(rq)
  );
endmodule

//--- core/ubt_top.sv
// Baud tick generation, receive sampler and transmitter behind a Wishbone slave
// How it works
// - A sub-bit tick fires every divisor plus one counted base clock cycles.
// - The bit-length selector sets 15 to 17 ticks per serial bit.
// - Codes 000, 010, 100 give fixed 16, 15 and 17 tick bits.
// - Codes 001 and 011 alternate 16/17 and 15/16, start bit shorter.
// - Transmit and receive share the same divisor and per-bit tick count.
// - Receiver idles until a falling edge on serial input, then counts ticks.
// - Each bit counts down from its tick count minus one to zero.
// - Input is sampled at down-count values eight, seven and six.
// - Bit value is the level seen in two of three samples.
// - Sample positions stay at eight to six for every bit length.
// - A start bit voted high stops counting and drops the frame.
// - After a false start, the next falling edge restarts reception.
// - Frame: low start, eight data bits LSB first, optional parity, 1-2 stops.
module ubt_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial line
  input wire logic serial_in,
  output logic serial_out
);
  logic [7:0] ctrl;
  logic [7:0] baud_divisor;
  logic [2:0] bit_length_select;
  logic rx_enable;
  logic tx_enable;
  logic parity_enable;
  logic stop_bit_count;
  logic [1:0] base_clock_select;
  logic [2:0] presc;
  logic base_en;
  logic [3:0] frame_last;
  logic wb_req;
  logic bus_wr;
  logic overrun;
  logic [7:0] false_starts;
  // Receive side
  ubt_pkg::ubt_state_t rx_state;
  logic rx_prev;
  logic rx_fall;
  logic [7:0] rx_div;
  logic rx_tick;
  logic [4:0] rx_rt;
  logic rx_phase;
  logic [3:0] rx_idx;
  logic [1:0] rx_samp;
  logic vote_tick;
  logic vote;
  logic [7:0] rx_data;
  logic rx_perr;
  logic rx_ferr;
  logic push;
  logic [9:0] push_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [9:0] fifo_out_data;
  // Transmit side
  ubt_pkg::ubt_state_t tx_state;
  logic [7:0] tx_div;
  logic tx_tick;
  logic [4:0] tx_rt;
  logic tx_phase;
  logic [11:0] tx_shift;
  logic [3:0] tx_left;
  logic tx_load;
  logic [31:0] rd_value;

  assign rx_enable = ctrl[ubt_pkg::CTRL_RX_EN];
  assign tx_enable = ctrl[ubt_pkg::CTRL_TX_EN];
  assign parity_enable = ctrl[ubt_pkg::CTRL_PAR];
  assign stop_bit_count = ctrl[ubt_pkg::CTRL_STOP];
  assign base_clock_select = ctrl[ubt_pkg::CTRL_BASE_LO +: 2];
  // Index of the final stop bit
  assign frame_last = ubt_pkg::FRAME_LAST_BASE + {3'h0, parity_enable} + {3'h0, stop_bit_count};

  // Base clock: core clock divided by 1, 2, 4 or 8
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc <= 3'h0;
    end else begin
      presc <= presc + 3'h1;
    end
  end

  always_comb begin
    base_en = 1'b1;
    unique case (base_clock_select)
      2'h0: base_en = 1'b1;
      2'h1: base_en = presc[0] == 1'b0;
      2'h2: base_en = presc[1:0] == 2'h0;
      2'h3: base_en = presc == 3'h0;
    endcase
  end

  // Wishbone: every access answered one cycle after it is seen
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = wb_req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= ubt_pkg::CTRL_RST;
      baud_divisor <= ubt_pkg::DIV_RST;
      bit_length_select <= ubt_pkg::BITLEN_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == ubt_pkg::ADR_CTRL) begin
        ctrl <= {2'h0, wb_dat_i[5:0]};
      end
      if (wb_adr_i == ubt_pkg::ADR_DIV) begin
        baud_divisor <= wb_dat_i[7:0];
      end
      if (wb_adr_i == ubt_pkg::ADR_BITLEN) begin
        bit_length_select <= wb_dat_i[2:0];
      end
    end
  end

  always_comb begin
    rd_value = 32'h0;
    unique case (wb_adr_i)
      ubt_pkg::ADR_CTRL: rd_value = {24'h0, ctrl};
      ubt_pkg::ADR_DIV: rd_value = {24'h0, baud_divisor};
      ubt_pkg::ADR_BITLEN: rd_value = {29'h0, bit_length_select};
      ubt_pkg::ADR_STAT: rd_value = {16'h0, false_starts, 4'h0, overrun, fifo_out_valid,
                                     tx_state == ubt_pkg::ST_RUN, rx_state == ubt_pkg::ST_RUN};
      ubt_pkg::ADR_DATA: rd_value = {21'h0, fifo_out_valid, fifo_out_valid ? fifo_out_data : 10'h0};
      default: rd_value = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0;
    end else if (wb_req) begin
      wb_dat_o <= wb_we_i ? 32'h0 : rd_value;
    end
  end
  // Reading the data register takes the word it returns
  assign fifo_out_ready = wb_req & ~wb_we_i & (wb_adr_i == ubt_pkg::ADR_DATA);
  // Overrun stays set until software writes one; a new overrun wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun <= 1'b0;
    end else if (push & ~fifo_in_ready) begin
      overrun <= 1'b1;
    end else if (bus_wr && wb_adr_i == ubt_pkg::ADR_STAT && wb_dat_i[ubt_pkg::STAT_OVERRUN]) begin
      overrun <= 1'b0;
    end
  end

  // Receive timing
  assign rx_fall = rx_prev & ~serial_in;
  assign rx_tick = base_en && rx_div == baud_divisor && rx_state == ubt_pkg::ST_RUN;
  assign vote_tick = rx_tick && rx_rt == ubt_pkg::SAMPLE_LAST;
  assign vote = ubt_pkg::majority({rx_samp, serial_in});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= serial_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state <= ubt_pkg::ST_IDLE;
      rx_div <= 8'h00;
      rx_rt <= 5'h00;
      rx_phase <= 1'b0;
      rx_idx <= 4'h0;
    end else begin
      unique case (rx_state)
        ubt_pkg::ST_IDLE: begin
          if (rx_enable && rx_fall) begin
            rx_state <= ubt_pkg::ST_RUN;
            rx_div <= 8'h00;
            rx_phase <= 1'b0;
            rx_rt <= ubt_pkg::bit_ticks(bit_length_select, 1'b0) - 5'h01;
            rx_idx <= 4'h0;
          end
        end
        ubt_pkg::ST_RUN: begin
          if (!rx_enable) begin
            rx_state <= ubt_pkg::ST_IDLE;
          end else begin
            if (base_en) begin
              rx_div <= (rx_div == baud_divisor) ? 8'h00 : rx_div + 8'h01;
            end
            if (vote_tick && rx_idx == 4'h0 && vote) begin
              rx_state <= ubt_pkg::ST_IDLE;
            end else if (vote_tick && rx_idx == frame_last) begin
              // Leave at the last stop decision so an early next start edge is seen
              rx_state <= ubt_pkg::ST_IDLE;
            end else if (rx_tick) begin
              if (rx_rt == 5'h00) begin
                rx_idx <= rx_idx + 4'h1;
                rx_phase <= ~rx_phase;
                rx_rt <= ubt_pkg::bit_ticks(bit_length_select, ~rx_phase) - 5'h01;
              end else begin
                rx_rt <= rx_rt - 5'h01;
              end
            end
          end
        end
      endcase
    end
  end

  // Receive sampling and frame assembly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_samp <= 2'h0;
    end else if (rx_tick && (rx_rt == ubt_pkg::SAMPLE_FIRST || rx_rt == ubt_pkg::SAMPLE_MID)) begin
      rx_samp <= {rx_samp[0], serial_in};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data <= 8'h00;
      rx_perr <= 1'b0;
      rx_ferr <= 1'b0;
    end else if (vote_tick) begin
      if (rx_idx == 4'h0) begin
        rx_perr <= 1'b0;
        rx_ferr <= 1'b0;
      end else if (rx_idx <= 4'h8) begin
        rx_data <= {vote, rx_data[7:1]};
      end else if (parity_enable && rx_idx == 4'h9) begin
        rx_perr <= vote ^ (^rx_data);
      end else if (!vote) begin
        rx_ferr <= 1'b1;
      end
    end
  end

  assign push = vote_tick && rx_idx == frame_last && rx_state == ubt_pkg::ST_RUN && rx_enable;
  assign push_data = {rx_ferr | ~vote, rx_perr, rx_data};

  ubt_fifo #(.WIDTH(ubt_pkg::FIFO_WIDTH), .DEPTH(ubt_pkg::FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      false_starts <= 8'h00;
    end else if (vote_tick && rx_idx == 4'h0 && vote && rx_enable) begin
      false_starts <= false_starts + 8'h01;
    end
  end

  // Transmitter: a data write while idle with transmit enabled starts a frame, otherwise it is ignored
  assign tx_load = bus_wr && wb_adr_i == ubt_pkg::ADR_DATA && tx_enable && tx_state == ubt_pkg::ST_IDLE;
  assign tx_tick = base_en && tx_div == baud_divisor && tx_state == ubt_pkg::ST_RUN;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state <= ubt_pkg::ST_IDLE;
      tx_div <= 8'h00;
      tx_rt <= 5'h00;
      tx_phase <= 1'b0;
      tx_shift <= 12'hFFF;
      tx_left <= 4'h0;
      serial_out <= 1'b1;
    end else begin
      unique case (tx_state)
        ubt_pkg::ST_IDLE: begin
          serial_out <= 1'b1;
          if (tx_load) begin
            tx_state <= ubt_pkg::ST_RUN;
            tx_div <= 8'h00;
            tx_phase <= 1'b0;
            tx_rt <= ubt_pkg::bit_ticks(bit_length_select, 1'b0) - 5'h01;
            // Parity is even; without parity that slot is already a stop bit
            tx_shift <= {2'h3, parity_enable ? ^wb_dat_i[7:0] : 1'b1, wb_dat_i[7:0], 1'b0};
            tx_left <= frame_last + 4'h1;
            serial_out <= 1'b0;
          end
        end
        ubt_pkg::ST_RUN: begin
          if (base_en) begin
            tx_div <= (tx_div == baud_divisor) ? 8'h00 : tx_div + 8'h01;
          end
          if (tx_tick) begin
            if (tx_rt == 5'h00) begin
              tx_phase <= ~tx_phase;
              tx_rt <= ubt_pkg::bit_ticks(bit_length_select, ~tx_phase) - 5'h01;
              tx_shift <= {1'b1, tx_shift[11:1]};
              tx_left <= tx_left - 4'h1;
              serial_out <= tx_shift[1];
              if (tx_left == 4'h1) begin
                tx_state <= ubt_pkg::ST_IDLE;
                serial_out <= 1'b1;
              end
            end else begin
              tx_rt <= tx_rt - 5'h01;
            end
          end
        end
      endcase
    end
  end
  // Checks
  a_start_restart: assert property (@(posedge clk) disable iff (rst)
    (rx_state == ubt_pkg::ST_IDLE && rx_enable && rx_fall) |=>
      (rx_state == ubt_pkg::ST_RUN && rx_div == 8'h00 && rx_phase == 1'b0 && rx_idx == 4'h0))
    else $error("receive counters not restarted at start edge");
  a_start_count: assert property (@(posedge clk) disable iff (rst)
    $rose(rx_state == ubt_pkg::ST_RUN) |-> rx_rt == ubt_pkg::bit_ticks(bit_length_select, 1'b0) - 5'h01)
    else $error("start bit down-count does not begin at tick count minus one");
  a_bit_reload: assert property (@(posedge clk) disable iff (rst)
    (rx_tick && rx_rt == 5'h00 && $stable(bit_length_select)) ##1 (rx_state == ubt_pkg::ST_RUN) |->
      rx_phase != $past(rx_phase) && rx_rt == ubt_pkg::bit_ticks(bit_length_select, rx_phase) - 5'h01)
    else $error("bit length reload or alternation wrong");
  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    (rx_tick && base_clock_select == 2'h0 && baud_divisor == 8'h02 && $stable(baud_divisor))
      ##1 (rx_state == ubt_pkg::ST_RUN) [*2] |-> !$past(rx_tick) && !rx_tick)
    else $error("sub-bit tick faster than divisor plus one");
  a_sample_window: assert property (@(posedge clk) disable iff (rst)
    (rx_samp != $past(rx_samp)) |-> $past(rx_tick) && ($past(rx_rt) == 5'h08 || $past(rx_rt) == 5'h07))
    else $error("sample taken outside down-count eight to seven");
  a_false_start: assert property (@(posedge clk) disable iff (rst)
    (vote_tick && rx_idx == 4'h0 && ubt_pkg::majority({rx_samp, serial_in})) |=>
      rx_state == ubt_pkg::ST_IDLE ##1 (rx_state == ubt_pkg::ST_IDLE || $past(rx_fall)))
    else $error("false start did not abandon reception");
  a_start_keep: assert property (@(posedge clk) disable iff (rst)
    (vote_tick && rx_idx == 4'h0 && rx_enable && (rx_samp == 2'h0 || (rx_samp != 2'h3 && !serial_in)))
      |=> rx_state == ubt_pkg::ST_RUN)
    else $error("start bit voted low but reception dropped");
  a_idle_wait: assert property (@(posedge clk) disable iff (rst)
    (rx_state == ubt_pkg::ST_IDLE && !rx_fall) |=> rx_state == ubt_pkg::ST_IDLE)
    else $error("receiver left idle without a falling edge");
  a_tx_start_low: assert property (@(posedge clk) disable iff (rst)
    tx_load |=> !serial_out && tx_state == ubt_pkg::ST_RUN &&
      tx_rt == ubt_pkg::bit_ticks(bit_length_select, 1'b0) - 5'h01)
    else $error("transmit frame did not begin with a low start bit");
  a_ack_single: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule

//--- tb/ubt_serial_peer.sv
// Far-end serial transceiver model: sends and captures frames
module ubt_serial_peer (
  // Clock
  input wire logic clk,
  // Serial line
  input wire logic serial_out,
  output logic serial_in,
  // Link settings
  input wire logic [7:0] div,
  input wire logic [2:0] sel,
  input wire logic par_en,
  input wire logic stop2
);
  timeunit 1ns;
  timeprecision 100ps;

  initial serial_in = 1'b1;

  function automatic int ticks(input logic [2:0] s, input logic ph);
    case (s)
      3'h1: return ph ? 17 : 16;
      3'h2: return 15;
      3'h3: return ph ? 16 : 15;
      3'h4: return 17;
      default: return 16;
    endcase
  endfunction

  function automatic int bit_len(input logic ph);
    return ticks(sel, ph) * (int'(div) + 1);
  endfunction

  task automatic hold(input logic lvl, input int n);
    serial_in <= lvl;
    repeat (n) @(posedge clk);
  endtask

  // Start low, data LSB first, even parity, stops; phase toggles each bit
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic ph;
    ph = 1'b0;
    @(posedge clk);
    hold(1'b0, bit_len(ph));
    for (int i = 0; i < 8; i++) begin
      ph = ~ph;
      hold(d[i], bit_len(ph));
    end
    if (par_en) begin
      ph = ~ph;
      hold(^d ^ bad_par, bit_len(ph));
    end
    for (int i = 0; i < (stop2 ? 2 : 1); i++) begin
      ph = ~ph;
      hold(~bad_stop, bit_len(ph));
    end
    serial_in <= 1'b1;
  endtask

  task automatic glitch(input int n);
    @(posedge clk);
    hold(1'b0, n);
    serial_in <= 1'b1;
  endtask

  // Needs data bit 0 high and bit 1 low to time the first two bits
  task automatic recv(output logic [7:0] d, output logic p, output int len0, output int len1);
    logic ph;
    while (serial_out !== 1'b0) @(posedge clk);
    len0 = 0;
    while (serial_out === 1'b0) begin
      len0++;
      @(posedge clk);
    end
    len1 = 0;
    while (serial_out === 1'b1 && len1 < 2000) begin
      len1++;
      @(posedge clk);
    end
    d = 8'h01;
    p = 1'b0;
    ph = 1'b0;
    for (int i = 1; i < 9; i++) begin
      if (i < 8 || par_en) begin
        repeat (bit_len(ph) / 2) @(posedge clk);
        if (i < 8) d[i] = serial_out;
        else p = serial_out;
        repeat (bit_len(ph) - bit_len(ph) / 2) @(posedge clk);
      end
      ph = ~ph;
    end
  endtask
endmodule

//--- tb/test_ubt_top.sv
// Register and serial-line tests for the baud tick and receive sampler
module test_ubt_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic serial_in;
  logic serial_out;
  logic [7:0] div = 8'h00;
  logic [2:0] bl = 3'h0;
  logic par_en = 1'b0;
  logic stop2 = 1'b0;
  logic [31:0] q;
  logic [7:0] d;
  logic p;
  int l0;
  int l1;
  int error_cnt = 0;
  int compares = 0;

  always #2.5 clk = ~clk;

  ubt_top ubt_top_inst (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .serial_in(serial_in),
    .serial_out(serial_out));

  ubt_serial_peer ubt_serial_peer_inst (.clk(clk), .serial_out(serial_out), .serial_in(serial_in), .div(div),
    .sel(bl), .par_en(par_en), .stop2(stop2));

  task automatic print_verdict;
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= v;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask

  task automatic cfg(input logic [7:0] c, input logic [7:0] dv, input logic [2:0] s);
    wb(1'b1, ubt_pkg::ADR_CTRL, {24'h0, c}, q);
    wb(1'b1, ubt_pkg::ADR_DIV, {24'h0, dv}, q);
    wb(1'b1, ubt_pkg::ADR_BITLEN, {29'h0, s}, q);
    div = dv;
    bl = s;
    par_en = c[ubt_pkg::CTRL_PAR];
    stop2 = c[ubt_pkg::CTRL_STOP];
  endtask

  // Sends one frame, then reads the receive word after the buffer latency
  task automatic rx_frame(input logic [7:0] v, input logic bp, input logic bs);
    ubt_serial_peer_inst.send(v, bp, bs);
    repeat (8) @(posedge clk);
    wb(1'b0, ubt_pkg::ADR_DATA, 32'h0, q);
    check(q, {21'h0, 1'b1, bs, bp, v});
  endtask

  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, ubt_pkg::ADR_CTRL, 32'h0, q);
    check(q, {24'h0, ubt_pkg::CTRL_RST});
    wb(1'b0, ubt_pkg::ADR_DIV, 32'h0, q);
    check(q, {24'h0, ubt_pkg::DIV_RST});
    wb(1'b0, ubt_pkg::ADR_BITLEN, 32'h0, q);
    check(q, {29'h0, ubt_pkg::BITLEN_RST});
    wb(1'b0, 8'h20, 32'h0, q);
    check(q, 32'h0);
    wb(1'b1, ubt_pkg::ADR_DIV, 32'h1FF, q);
    wb(1'b0, ubt_pkg::ADR_DIV, 32'h0, q);
    check(q, 32'hFF);
    // Every bit-length code, each with its own divisor
    for (int s = 0; s < 5; s++) begin
      cfg(8'h03, 8'(s + 1), 3'(s));
      fork
        ubt_serial_peer_inst.recv(d, p, l0, l1);
        wb(1'b1, ubt_pkg::ADR_DATA, 32'h35, q);
      join
      check({24'h0, d}, 32'h35);
      check(32'(l0), 32'(ubt_serial_peer_inst.ticks(3'(s), 1'b0) * (s + 2)));
      check(32'(l1), 32'(ubt_serial_peer_inst.ticks(3'(s), 1'b1) * (s + 2)));
      rx_frame(8'hC0 + 8'(s), 1'b0, 1'b0);
    end
    cfg(8'h0F, 8'h02, ubt_pkg::BL_16);
    fork
      ubt_serial_peer_inst.recv(d, p, l0, l1);
      wb(1'b1, ubt_pkg::ADR_DATA, 32'h35, q);
    join
    check({31'h0, p}, {31'h0, ^8'h35});
    rx_frame(8'h96, 1'b0, 1'b0);
    rx_frame(8'h96, 1'b1, 1'b0);
    rx_frame(8'h3C, 1'b0, 1'b1);
    // Short low pulse is a false start; the next edge starts a real frame
    cfg(8'h01, 8'h01, ubt_pkg::BL_16);
    wb(1'b0, ubt_pkg::ADR_STAT, 32'h0, q);
    d = q[15:8] + 8'h01;
    ubt_serial_peer_inst.glitch(6);
    repeat (80) @(posedge clk);
    wb(1'b0, ubt_pkg::ADR_STAT, 32'h0, q);
    check({24'h0, q[15:8]}, {24'h0, d});
    rx_frame(8'h5A, 1'b0, 1'b0);
    // Slower base clocks: the peer counts its divisor in core clocks
    for (int b = 1; b < 4; b++) begin
      cfg({2'h0, 2'(b), 4'h1}, 8'h01, ubt_pkg::BL_16);
      div = 8'((2 << b) - 1);
      rx_frame(8'hA0 + 8'(b), 1'b0, 1'b0);
    end
    // Fill the buffer past its depth, then drain it
    cfg(8'h01, 8'h00, ubt_pkg::BL_16);
    for (int i = 0; i < 34; i++) ubt_serial_peer_inst.send(8'(i), 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    wb(1'b0, ubt_pkg::ADR_STAT, 32'h0, q);
    check({31'h0, q[ubt_pkg::STAT_OVERRUN]}, 32'h1);
    for (int i = 0; i < 33; i++) begin
      wb(1'b0, ubt_pkg::ADR_DATA, 32'h0, q);
      check(q, {21'h0, 1'b1, 2'h0, 8'(i)});
    end
    wb(1'b0, ubt_pkg::ADR_DATA, 32'h0, q);
    check(q, 32'h0);
    wb(1'b1, ubt_pkg::ADR_STAT, 32'h8, q);
    wb(1'b0, ubt_pkg::ADR_STAT, 32'h0, q);
    check({31'h0, q[ubt_pkg::STAT_OVERRUN]}, 32'h0);
    print_verdict();
  end
endmodule
